// *** config_port_abort_recovery_bench.sv ***
// Self-checking bench for the configuration port abort logic.
`timescale 1ns/1ps
`default_nettype none
module config_port_abort_recovery_bench
	import cpar_pkg::*;
;
	logic ref_clk = 1'b0;
	logic config_clock = 1'b0;
	logic resetn = 1'b0;
	logic program_restart_n = 1'b1;
	logic port_select_n, read_write_select, port_enable, port_write;
	logic [7:0] internal_write_data, pin_data_out, pin_data_oe, internal_read_data;
	logic [7:0] core_read_data = 8'h3c;
	logic [7:0] accepted_data;
	logic accepted_valid;
	logic busy_out, busy_oe, internal_busy, internal_selected, abort_active, restart_pulse;
	cpar_status_t core_status = '0;
	wire logic [7:0] pin_data_in;
	int miscompares = 0;
	int cmp_count = 0;
	always #2.5 ref_clk = ~ref_clk;
	always #62.5 config_clock = ~config_clock;
	assign pin_data_in = pin_data_oe[0] ? pin_data_out : internal_write_data;
	cpar_abort cpar_abort_inst (.ref_clk, .resetn, .config_clock, .program_restart_n,
		.port_select_n, .read_write_select, .pin_data_in, .pin_data_out, .pin_data_oe,
		.busy_out, .busy_oe, .port_enable, .port_write, .internal_write_data,
		.internal_read_data, .internal_busy, .core_status, .core_read_data,
		.accepted_data, .accepted_valid, .internal_selected, .abort_active,
		.restart_pulse);
	cpar_host cpar_host_inst (.config_clock, .port_select_n, .read_write_select,
		.port_enable, .port_write, .internal_write_data);
	function automatic logic [7:0] exp_status(input cpar_status_t s);
		return {s.config_error_n, s.sync_aligned, s.readback_active, 1'b0, CPAR_STATUS_LOW};
	endfunction : exp_status
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic w(input int n);
		repeat (n) @(posedge config_clock);
		#1;
	endtask : w
	task automatic end_sim();
		$display("compares=%0d mismatches=%0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_sim
	initial begin
		#200000;
		miscompares++;
		end_sim();
	end
	initial begin
		logic i;
		logic d;
		void'($urandom(32'h90af7b87));
		repeat (12) @(posedge ref_clk);
		#1;
		resetn = 1'b1;
		w(4);
		for (int k = 0; k < 8; k++) begin
			i = k[0];
			d = k[1];
			core_status = cpar_status_t'({3'($urandom), 2'b00});
			cpar_host_inst.sel(i, d);
			w(2);
			cpar_host_inst.flip();
			w(3);
			if (!d) chk({7'h00, i ? internal_busy : busy_out}, 8'h01);
			w(1);
			chk({7'h00, abort_active}, 8'h01);
			chk({7'h00, accepted_valid}, 8'h00);
			if (!d) chk(i ? internal_read_data : pin_data_out, exp_status(core_status));
			if (!i) chk(pin_data_oe, d ? 8'h00 : 8'hff);
			if (!i && d) chk({7'h00, busy_oe}, 8'h00);
			if (i) chk({7'h00, internal_selected}, 8'h01);
			w(3);
			chk({7'h00, i ? internal_busy : busy_out}, 8'h00);
			cpar_host_inst.off();
			w(3);
		end
		// Going back to read in mid-abort must still show the status byte.
		cpar_host_inst.sel(1'b0, 1'b1);
		w(2);
		cpar_host_inst.flip();
		w(1);
		cpar_host_inst.flip();
		w(3);
		chk(pin_data_out, exp_status(core_status));
		cpar_host_inst.off();
		w(8);
		cpar_host_inst.sel(1'b0, 1'b0);
		// After the abort the host reselects write and streams again; the byte sampled is
		// the one before the walk stepped.
		w(1);
		chk({7'h00, accepted_valid}, 8'h01);
		chk(accepted_data, 8'h00 - internal_write_data);
		cpar_host_inst.flip();
		w(2);
		program_restart_n = 1'b0;
		w(1);
		chk({6'h00, restart_pulse, busy_out}, 8'h02);
		program_restart_n = 1'b1;
		cpar_host_inst.off();
		w(6);
		core_status = cpar_status_t'(5'h1b);
		cpar_host_inst.sel(1'b1, 1'b0);
		w(2);
		chk({7'h00, internal_selected}, 8'h00);
		cpar_host_inst.off();
		end_sim();
	end
endmodule : config_port_abort_recovery_bench
`default_nettype wire

// *** cpar_abort.sv ***
// Abort detection and status reporting for the byte-wide slave configuration port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RQ1 - Select change under chip select starts abort
// RQ2 - Configuration abort: busy high, status byte driven
// RQ3 - Abort lasts exactly four configuration clocks
// RQ4 - Readback abort at write: busy, data tristated
// RQ5 - Read select during readback abort shows status
// RQ6 - Readback abort kept at write: no status
// RQ7 - Status bit 7 is configuration error low
// RQ8 - Status bit 6 is sync word aligned
// RQ9 - Status bit 5 is readback in progress
// RQ10 - Status bit 4 is abort active low
// RQ11 - Status bits 3 to 0 read ones
// RQ12 - Host may resend sync word after abort
// RQ13 - Restart pin clears configuration any time
// RQ14 - Host recovery: sync, length, read, address
// RQ15 - Host recovery: header, no-ops, read frame
// RQ16 - Host resumes readback with read commands
// RQ17 - Host resumes configuration with write commands
// RQ18 - Internal port follows same slave protocol
// RQ19 - Internal port disabled after done if kept
// RQ20 - No scan config instructions during internal use
// RQ21 - Desynchronize before switching interfaces
// RQ22 - Select may change only without clocked chip select
// RQ23 - Write select inputs data, read drives data
module cpar_abort
	import cpar_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic config_clock,
	input wire logic program_restart_n,
	input wire logic port_select_n,
	input wire logic read_write_select,
	input wire logic [7:0] pin_data_in,
	output logic [7:0] pin_data_out,
	output logic [7:0] pin_data_oe,
	output logic busy_out,
	output logic busy_oe,
	input wire logic port_enable,
	input wire logic port_write,
	input wire logic [7:0] internal_write_data,
	output logic [7:0] internal_read_data,
	output logic internal_busy,
	input wire cpar_status_t core_status,
	input wire logic [7:0] core_read_data,
	output logic [7:0] accepted_data,
	output logic accepted_valid,
	output logic internal_selected,
	output logic abort_active,
	output logic restart_pulse
);
	// The link side runs on config_clock; ref_clk only hosts the reset synchroniser
	// and a level crossing that reports abort activity to system logic.
	logic rst_meta;
	logic rst_sync;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// The link reset combines system reset and the restart pin; released synchronously.
	wire link_rst_n_async = rst_sync & program_restart_n;
	logic lrst_meta;
	logic link_rst_n;
	always_ff @(posedge config_clock or negedge link_rst_n_async) begin
		if (!link_rst_n_async) begin
			lrst_meta <= 1'b0;
			link_rst_n <= 1'b0;
		end else begin
			lrst_meta <= 1'b1;
			link_rst_n <= lrst_meta;
		end
	end

	// Port selection: internal port disabled after done when the keep bit is set.
	logic int_disabled;
	always_ff @(posedge config_clock or negedge link_rst_n_async) begin
		if (!link_rst_n_async) begin
			int_disabled <= 1'b0;
		end else if (core_status.config_done && core_status.keep_port_after_config) begin
			int_disabled <= 1'b1; // [RQ19]
		end
	end
	wire int_ena = !port_enable && !int_disabled; // [RQ18]
	wire ext_ena = !port_select_n && !int_ena; // [RQ19]
	wire sel_active = int_ena || ext_ena;
	wire sel_rw = int_ena ? port_write : read_write_select; // [RQ18]
	wire [7:0] sel_in = int_ena ? internal_write_data : pin_data_in;

	// Abort detection and sequencing.
	cpar_state_t state;
	cpar_state_t next_state;
	logic [2:0] cnt;
	logic [2:0] next_cnt;
	logic last_rw;
	logic was_active;
	logic abort_in_rdbk;
	wire rw_changed = sel_active && was_active && (sel_rw != last_rw);
	wire abort_start = (state == cpar_idle_s) && rw_changed; // [RQ1]
	wire abort_end = (state == cpar_abort_s) && (cnt == CPAR_ABORT_LAST); // [RQ3]

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			cpar_idle_s: begin
				if (abort_start) begin
					next_state = cpar_abort_s;
					next_cnt = 3'h0;
				end
			end
			cpar_abort_s: begin
				if (abort_end) begin
					next_state = cpar_idle_s; // [RQ3]
				end else begin
					next_cnt = cnt + 3'h1;
				end
			end
			default: begin
				next_state = cpar_idle_s;
			end
		endcase
	end

	always_ff @(posedge config_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			state <= cpar_idle_s;
			cnt <= 3'h0;
			last_rw <= 1'b0;
			was_active <= 1'b0;
			abort_in_rdbk <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			last_rw <= sel_rw;
			was_active <= sel_active;
			if (abort_start) begin
				abort_in_rdbk <= core_status.readback_active;
			end
		end
	end

	wire in_abort = (state == cpar_abort_s);

	// Status byte assembled from core status and abort state.
	logic [7:0] status_byte;
	always_comb begin
		status_byte[3:0] = CPAR_STATUS_LOW; // [RQ11]
		status_byte[CPAR_BIT_ABORT] = !in_abort; // [RQ10]
		status_byte[CPAR_BIT_RDBK] = core_status.readback_active; // [RQ9]
		status_byte[CPAR_BIT_ALIGN] = core_status.sync_aligned; // [RQ8]
		status_byte[CPAR_BIT_CFGERR] = core_status.config_error_n; // [RQ7]
	end

	// Output choice: status during abort when read selected, else core data.
	wire show_status = in_abort && sel_rw; // [RQ2] [RQ5]
	wire [7:0] next_dout = show_status ? status_byte : core_read_data;
	wire drive_data = sel_active && sel_rw; // [RQ23]
	wire drive_busy = sel_active && (sel_rw || !in_abort); // [RQ4] [RQ6]

	logic [7:0] dout;
	logic busy_q;
	always_ff @(posedge config_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			dout <= CPAR_DATA_RESET;
			busy_q <= 1'b0;
			accepted_data <= CPAR_DATA_RESET;
			accepted_valid <= 1'b0;
		end else begin
			dout <= next_dout;
			busy_q <= next_state == cpar_abort_s; // [RQ2]
			accepted_data <= sel_in;
			accepted_valid <= sel_active && !sel_rw && !in_abort && !abort_start;
		end
	end

	assign pin_data_out = dout;
	// Every data pin shares one enable, so the bus never shows a half-driven byte.
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_data_oe
			assign pin_data_oe[gi] = drive_data && ext_ena; // [RQ4] [RQ23]
		end
	endgenerate
	assign busy_out = busy_q;
	assign busy_oe = drive_busy && ext_ena; // [RQ4]
	assign internal_read_data = dout; // [RQ18]
	assign internal_busy = busy_q;
	assign internal_selected = int_ena;
	assign restart_pulse = !link_rst_n; // [RQ13]

	// Abort activity handed to the system clock through two flip-flops.
	logic ab_meta;
	logic ab_sync;
	always_ff @(posedge ref_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			ab_meta <= 1'b0;
			ab_sync <= 1'b0;
		end else begin
			ab_meta <= busy_q;
			ab_sync <= ab_meta;
		end
	end
	assign abort_active = ab_sync;

	// Checks on the abort sequence.
	sequence s_abort_run;
		in_abort [*4];
	endsequence

	sequence s_busy_run;
		busy_q [*4];
	endsequence

	// A direction change seen on two clocked edges under select, outside an abort.
	sequence s_idle_flip;
		!in_abort && sel_active && was_active && (sel_rw != last_rw);
	endsequence

	a_abort_start_entry: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ1]
		abort_start |=> in_abort)
		else $error("abort not entered after select change");
	a_abort_length_four: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ3]
		abort_start |=> s_abort_run ##1 !in_abort)
		else $error("abort did not last four cycles");
	a_config_busy_high: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ2]
		in_abort && $past(in_abort) |-> busy_q)
		else $error("busy not high during abort");
	a_status_during_read: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ5]
		$past(in_abort) && $past(sel_rw) |-> dout[3:0] == 4'hf)
		else $error("status byte not shown in abort");
	a_readback_tristate: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ4]
		in_abort && !sel_rw |-> pin_data_oe == 8'h00 && !busy_oe)
		else $error("pins driven in write abort");
	a_no_status_write: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ6]
		in_abort && !sel_rw |-> !show_status)
		else $error("status selected while at write");
	a_abort_flag_low: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ10]
		in_abort |-> !status_byte[CPAR_BIT_ABORT] && status_byte[7] == core_status.config_error_n)
		else $error("status flag bits wrong");
	a_keep_disables_int: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ19]
		core_status.config_done && core_status.keep_port_after_config |=> !int_ena)
		else $error("internal port still enabled");
	a_write_inputs: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ23]
		!read_write_select |-> pin_data_oe == 8'h00)
		else $error("data driven at write select");

	a_flip_starts_abort: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ1]
		s_idle_flip |=> in_abort && cnt == 3'h0)
		else $error("direction change did not start abort");

	a_steady_no_abort: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ22]
		sel_active && was_active && sel_rw == last_rw && !in_abort |=> !in_abort)
		else $error("abort without direction change");

	a_busy_run_four: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ2]
		abort_start |=> s_busy_run ##1 !busy_q)
		else $error("busy not high for the abort");

	a_busy_clears_end: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ3]
		abort_end |=> !busy_q && !in_abort)
		else $error("abort did not end after last cycle");

	a_count_in_range: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ3]
		in_abort |-> cnt <= CPAR_ABORT_LAST)
		else $error("abort counter out of range");

	a_idle_busy_low: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ3]
		!in_abort |-> !busy_q)
		else $error("busy high outside abort");

	// Status bits are checked one cycle late because the data pins are registered.
	a_status_cfg_error: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ7]
		$past(show_status) |-> dout[CPAR_BIT_CFGERR] == $past(core_status.config_error_n))
		else $error("status bit 7 wrong");

	a_status_aligned: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ8]
		$past(show_status) |-> dout[CPAR_BIT_ALIGN] == $past(core_status.sync_aligned))
		else $error("status bit 6 wrong");

	a_status_readback: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ9]
		$past(show_status) |-> dout[CPAR_BIT_RDBK] == $past(core_status.readback_active))
		else $error("status bit 5 wrong");

	a_status_abort_bit: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ10]
		$past(show_status) |-> !dout[CPAR_BIT_ABORT])
		else $error("status bit 4 not low in abort");

	a_status_low_ones: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ11]
		$past(show_status) |-> dout[3:0] == CPAR_STATUS_LOW)
		else $error("status low nibble not ones");

	a_readback_status: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ5]
		in_abort && abort_in_rdbk && sel_rw |=> dout == $past(status_byte))
		else $error("readback abort status missing");

	a_write_abort_quiet: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ6]
		in_abort && !sel_rw |=> dout == $past(core_read_data))
		else $error("status byte shown at write");

	a_config_busy_oe: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ2]
		in_abort && sel_rw && ext_ena |-> busy_oe && pin_data_oe == 8'hff)
		else $error("busy or data not driven in abort");

	a_read_drives_data: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ23]
		ext_ena && read_write_select |-> pin_data_oe == 8'hff)
		else $error("data not driven at read select");

	a_data_follows_core: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ23]
		!show_status |=> dout == $past(core_read_data))
		else $error("read data not from core");

	a_no_accept_abort: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ1]
		$past(in_abort) |-> !accepted_valid)
		else $error("byte accepted during abort");

	a_accept_write: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ23]
		sel_active && !sel_rw && !in_abort && !abort_start |=> accepted_valid && accepted_data == $past(sel_in))
		else $error("write byte not accepted");

	// The restart pin asserts the link reset itself, so this one uses the system reset.
	a_restart_clears: assert property (@(posedge config_clock) disable iff (!rst_sync) // [RQ13]
		!program_restart_n |-> restart_pulse && !busy_q)
		else $error("restart did not clear the link");

	a_int_busy_mirror: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ18]
		int_ena && in_abort && $past(in_abort) |-> internal_busy)
		else $error("internal busy missing in abort");

	a_int_gates_ext: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ19]
		int_ena |-> !busy_oe && pin_data_oe == 8'h00)
		else $error("both ports active at once");

	a_disable_sticks: assert property (@(posedge config_clock) disable iff (!link_rst_n) // [RQ19]
		int_disabled |=> int_disabled)
		else $error("internal port re-enabled");
endmodule : cpar_abort
`default_nettype wire

// *** cpar_host.sv ***
// Host model for the external port and its internal twin.
`timescale 1ns/1ps
`default_nettype none
module cpar_host (
	input wire logic config_clock,
	output logic port_select_n,
	output logic read_write_select,
	output logic port_enable,
	output logic port_write,
	output logic [7:0] internal_write_data
);
	initial begin
		port_select_n = 1'b1;
		read_write_select = 1'b0;
		port_enable = 1'b1;
		port_write = 1'b0;
		internal_write_data = 8'h5a;
		// The byte alternates between 8'h5a and 8'ha6 every cycle, so a value one cycle stale never passes for a fresh one.
		forever begin
			@(posedge config_clock);
			internal_write_data <= ~internal_write_data + 8'h01;
		end
	end
	// Direction is set a cycle before select, so no edge sees it change under select.
	task automatic sel(input logic internal, input logic dir);
		@(posedge config_clock);
		#1;
		read_write_select = dir;
		port_write = dir;
		@(posedge config_clock);
		#1;
		port_select_n = internal;
		port_enable = !internal;
	endtask : sel
	task automatic flip();
		@(posedge config_clock);
		#1;
		read_write_select = !read_write_select;
		port_write = !port_write;
	endtask : flip
	// Deselecting between ports stands for desynchronising; no scan access is modelled.
	task automatic off();
		@(posedge config_clock);
		#1;
		port_select_n = 1'b1;
		port_enable = 1'b1;
	endtask : off
endmodule : cpar_host
`default_nettype wire

// *** cpar_pkg.sv ***
// Package with constants and carrier types for the configuration port abort logic.
package cpar_pkg;
	localparam int CPAR_ABORT_CYCLES = 4;
	localparam logic [2:0] CPAR_ABORT_LAST = 3'h3;
	localparam logic [3:0] CPAR_STATUS_LOW = 4'hf;
	localparam int CPAR_BIT_CFGERR = 7;
	localparam int CPAR_BIT_ALIGN = 6;
	localparam int CPAR_BIT_RDBK = 5;
	localparam int CPAR_BIT_ABORT = 4;
	localparam logic [7:0] CPAR_DATA_RESET = 8'h00;

	typedef enum logic [1:0] {
		cpar_idle_s,
		cpar_abort_s
	} cpar_state_t;

	typedef struct packed {
		logic config_error_n;
		logic sync_aligned;
		logic readback_active;
		logic config_done;
		logic keep_port_after_config;
	} cpar_status_t;

	typedef struct packed {
		logic [7:0] out_data;
		logic [7:0] data_oe;
		logic busy;
		logic busy_oe;
	} cpar_pins_t;
endpackage : cpar_pkg
